/* core/sei_monitor.sv */
// encoder input monitor: ssi, quadrature, proximity pair, apb registers
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module sei_monitor #(
	parameter int CYC_CLKS = sei_pkg::CYCLE_CLKS,
	parameter int GAP_MIN = sei_pkg::GAP_MIN_CLKS,
	parameter int GAP_MAX = sei_pkg::GAP_MAX_CLKS,
	parameter int CNT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ssi_clk_in,
	input wire logic ssi_data_in,
	output logic ssi_clk_out,
	output logic ssi_clk_oe,
	input wire logic inc_a,
	input wire logic inc_b,
	input wire logic pp_a,
	input wire logic pp_b,
	input wire logic prox_in,
	input wire logic xch_miso,
	output logic xch_sclk,
	output logic xch_mosi,
	output logic fault
);
	localparam int NF = sei_pkg::NFAULT;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [7:0] pins;
	logic s_clk, s_data, s_inca, s_incb, s_ppa, s_ppb, s_prox, s_miso;
	sei_sync #(.W(8)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({!ssi_clk_in, ssi_data_in, inc_a, inc_b, pp_a, pp_b, prox_in, xch_miso}),
		.q(pins)
	);
	// clock travels inverted so a cleared sync shows its high idle level, no false edge
	assign s_clk = !pins[7];
	assign {s_data, s_inca, s_incb, s_ppa, s_ppb, s_prox, s_miso} = pins[6:0];

	// processing cycle tick
	logic [23:0] tcnt;
	logic tick;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcnt <= 24'h00_0000;
			tick <= 1'b0;
		end else if (tcnt == 24'(CYC_CLKS - 1)) begin
			tcnt <= 24'h00_0000;
			tick <= 1'b1;
		end else begin
			tcnt <= tcnt + 24'h00_0001;
			tick <= 1'b0;
		end
	end

	// apb slave: one wait state, completion edge commits
	logic [31:0] ctrl, vel, rd_val;
	logic [NF-1:0] flt, flt_set;
	logic hit, acc;
	logic [CNT_W-1:0] inc_cnt, pp_cnt, prox_cnt;
	logic [31:0] pos, sstat;
	logic own_smp, peer_smp;
	assign acc = psel & penable & pready;
	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (paddr)
			sei_pkg::ADDR_CTRL: rd_val = ctrl;
			sei_pkg::ADDR_VEL: rd_val = vel;
			sei_pkg::ADDR_FAULT: rd_val = 32'(flt);
			sei_pkg::ADDR_POS: rd_val = pos;
			sei_pkg::ADDR_SSTAT: rd_val = sstat;
			sei_pkg::ADDR_INC: rd_val = 32'(inc_cnt);
			sei_pkg::ADDR_PP: rd_val = 32'(pp_cnt);
			sei_pkg::ADDR_PROX: begin
				rd_val = 32'(prox_cnt);
				rd_val[sei_pkg::PROX_OWN] = own_smp;
				rd_val[sei_pkg::PROX_PEER] = peer_smp;
			end
			default: hit = 1'b0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & penable & !pready;
			pslverr <= psel & penable & !pready & !hit;
			if (psel & penable & !pready & !pwrite) begin
				prdata <= rd_val;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= sei_pkg::CTRL_RESET;
			vel <= 32'h0000_0000;
		end else if (acc && pwrite && paddr == sei_pkg::ADDR_CTRL) begin
			ctrl <= pwdata;
		end else if (acc && pwrite && paddr == sei_pkg::ADDR_VEL) begin
			vel <= pwdata;
		end
	end

	// latched faults, write one to clear, a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flt <= '0;
			fault <= 1'b0;
		end else begin
			if (acc && pwrite && paddr == sei_pkg::ADDR_FAULT) begin
				flt <= (flt & ~pwdata[NF-1:0]) | flt_set;
			end else begin
				flt <= flt | flt_set;
			end
			fault <= |flt;
		end
	end

	logic master, gray;
	logic [4:0] dlen;
	logic [5:0] flen;
	assign master = ctrl[sei_pkg::CTRL_MASTER];
	assign gray = ctrl[sei_pkg::CTRL_GRAY];
	assign dlen = ctrl[sei_pkg::CTRL_DLEN_LSB +: 5];
	assign flen = ctrl[sei_pkg::CTRL_FLEN_LSB +: 6];

	// clock master: frame of flen pulses started each cycle
	sei_pkg::sei_mst_t mst;
	logic [9:0] hcnt;
	logic [5:0] mbits;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mst <= sei_pkg::SEI_M_IDLE;
			hcnt <= 10'h000;
			mbits <= 6'h00;
			ssi_clk_out <= 1'b1;
			ssi_clk_oe <= 1'b0;
		end else begin
			ssi_clk_oe <= master;
			unique case (mst)
				sei_pkg::SEI_M_IDLE: begin
					ssi_clk_out <= 1'b1;
					hcnt <= 10'h000;
					mbits <= 6'h00;
					if (tick && master) begin
						mst <= sei_pkg::SEI_M_LOW;
						ssi_clk_out <= 1'b0;
					end
				end
				sei_pkg::SEI_M_LOW: begin
					hcnt <= hcnt + 10'h001;
					if (hcnt == 10'(sei_pkg::SSI_HALF_CLKS - 1)) begin
						hcnt <= 10'h000;
						ssi_clk_out <= 1'b1;
						mbits <= mbits + 6'h01;
						mst <= sei_pkg::SEI_M_HIGH;
					end
				end
				sei_pkg::SEI_M_HIGH: begin
					hcnt <= hcnt + 10'h001;
					if (hcnt == 10'(sei_pkg::SSI_HALF_CLKS - 1)) begin
						hcnt <= 10'h000;
						if (mbits >= flen || !master) begin
							mst <= sei_pkg::SEI_M_IDLE;
						end else begin
							ssi_clk_out <= 1'b0;
							mst <= sei_pkg::SEI_M_LOW;
						end
					end
				end
			endcase
		end
	end

	// own clock delayed like the pin path so data lines up
	logic [1:0] own_dly;
	logic view, view_q, rise, edge_any;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			own_dly <= 2'b11;
			view_q <= 1'b1;
		end else begin
			own_dly <= {own_dly[0], ssi_clk_out};
			view_q <= view;
		end
	end
	assign view = master ? own_dly[1] : s_clk;
	assign rise = view & !view_q;
	assign edge_any = view ^ view_q;

	// shift register, bit count, idle gap and clock period
	logic [31:0] sreg;
	logic [5:0] bits;
	logic [23:0] icnt;
	logic [11:0] pcnt;
	logic gap_end;
	assign gap_end = (icnt == 24'(GAP_MIN - 1)) && (bits != 6'h00) && !edge_any;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sreg <= 32'h0000_0000;
			bits <= 6'h00;
			icnt <= 24'h00_0000;
			pcnt <= 12'h000;
		end else begin
			if (edge_any) begin
				icnt <= 24'h00_0000;
			end else if (icnt != 24'(GAP_MAX)) begin
				icnt <= icnt + 24'h00_0001;
			end
			if (rise) begin
				pcnt <= 12'h000;
			end else if (pcnt != 12'hfff) begin
				pcnt <= pcnt + 12'h001;
			end
			if (rise) begin
				sreg <= {sreg[30:0], s_data};
				bits <= (bits == 6'h3f) ? bits : bits + 6'h01;
			end else if (gap_end) begin
				bits <= 6'h00;
			end
		end
	end

	// gray to binary over the whole word; upper bits are zero
	function automatic logic [31:0] sei_g2b(input logic [31:0] g);
		logic [31:0] b;
		b[31] = g[31];
		for (int i = 30; i >= 0; i--) begin
			b[i] = b[i + 1] ^ g[i];
		end
		return b;
	endfunction : sei_g2b

	// frame accept: data bits first, status bits trail
	logic [31:0] raw, dmask, smask;
	logic [5:0] slen;
	logic len_ok;
	assign slen = flen - 6'(dlen);
	assign dmask = ~(32'hffff_ffff << dlen);
	assign smask = ~(32'hffff_ffff << slen);
	assign raw = (sreg >> slen) & dmask;
	assign len_ok = (bits == flen) && (flen >= 6'(dlen)) && (dlen >= 5'(sei_pkg::DATA_MIN))
		&& (dlen <= 5'(sei_pkg::DATA_MAX));
	logic pos_new, frame_ok;
	assign frame_ok = gap_end && len_ok;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos <= 32'h0000_0000;
			sstat <= 32'h0000_0000;
			pos_new <= 1'b0;
		end else begin
			if (frame_ok) begin
				pos <= gray ? sei_g2b(raw) : raw;
				sstat <= sreg & smask;
				pos_new <= 1'b1;
			end else if (tick) begin
				pos_new <= 1'b0;
			end
		end
	end

	// plausibility once per processing cycle
	logic [31:0] prev_pos, dabs;
	logic [32:0] vel2;
	logic have_prev, plaus_bad;
	assign dabs = (pos >= prev_pos) ? pos - prev_pos : prev_pos - pos;
	assign vel2 = {vel, 1'b0};
	assign plaus_bad = tick && pos_new && have_prev && ({1'b0, dabs} >= vel2);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_pos <= 32'h0000_0000;
			have_prev <= 1'b0;
		end else if (tick && pos_new) begin
			prev_pos <= pos;
			have_prev <= 1'b1;
		end
	end

	// quadrature inputs
	logic inc_trk, inc_ill, pp_trk, pp_ill;
	sei_quad #(.CNT_W(CNT_W)) u_inc (
		.pclk(pclk),
		.presetn(presetn),
		.a(s_inca),
		.b(s_incb),
		.count(inc_cnt),
		.trk_err(inc_trk),
		.ill_err(inc_ill)
	);
	sei_quad #(.CNT_W(CNT_W)) u_pp (
		.pclk(pclk),
		.presetn(presetn),
		.a(s_ppa),
		.b(s_ppb),
		.count(pp_cnt),
		.trk_err(pp_trk),
		.ill_err(pp_ill)
	);

	// proximity debounce and pulse count
	logic [9:0] dcnt;
	logic deb;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dcnt <= 10'h000;
			deb <= 1'b0;
			prox_cnt <= '0;
		end else if (s_prox == deb) begin
			dcnt <= 10'h000;
		end else if (dcnt == 10'(sei_pkg::DEB_CLKS - 1)) begin
			dcnt <= 10'h000;
			deb <= s_prox;
			if (s_prox) begin
				prox_cnt <= prox_cnt + CNT_W'(1);
			end
		end else begin
			dcnt <= dcnt + 10'h001;
		end
	end

	// sample at the tick, swap one bit with the other channel
	sei_pkg::sei_xch_t xst;
	logic [6:0] xcnt;
	logic pair_eval;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xst <= sei_pkg::SEI_X_IDLE;
			xcnt <= 7'h00;
			own_smp <= 1'b0;
			peer_smp <= 1'b0;
			xch_sclk <= 1'b0;
			xch_mosi <= 1'b0;
			pair_eval <= 1'b0;
		end else begin
			pair_eval <= 1'b0;
			unique case (xst)
				sei_pkg::SEI_X_IDLE: begin
					xch_sclk <= 1'b0;
					xcnt <= 7'h00;
					if (tick) begin
						own_smp <= deb;
						xch_mosi <= deb;
						xst <= sei_pkg::SEI_X_LOW;
					end
				end
				sei_pkg::SEI_X_LOW: begin
					xcnt <= xcnt + 7'h01;
					if (xcnt == 7'(sei_pkg::XCH_HALF_CLKS - 1)) begin
						xcnt <= 7'h00;
						xch_sclk <= 1'b1;
						xst <= sei_pkg::SEI_X_HIGH;
					end
				end
				sei_pkg::SEI_X_HIGH: begin
					xcnt <= xcnt + 7'h01;
					if (xcnt == 7'(sei_pkg::XCH_HALF_CLKS - 1)) begin
						peer_smp <= s_miso;
						pair_eval <= 1'b1;
						xch_sclk <= 1'b0;
						xst <= sei_pkg::SEI_X_IDLE;
					end
				end
			endcase
		end
	end

	// fault events gathered for the sticky register
	always_comb begin
		flt_set = '0;
		flt_set[sei_pkg::F_FREQ] = rise && (bits != 6'h00) && ((pcnt < 12'(sei_pkg::PER_MIN_CLKS - 1))
			|| (pcnt >= 12'(sei_pkg::PER_MAX_CLKS - 1)));
		flt_set[sei_pkg::F_PLAUS] = plaus_bad;
		flt_set[sei_pkg::F_FRAME] = gap_end && !len_ok;
		flt_set[sei_pkg::F_GAP] = !master && (icnt == 24'(GAP_MAX - 1)) && !edge_any;
		flt_set[sei_pkg::F_INC_TRK] = inc_trk;
		flt_set[sei_pkg::F_INC_ILL] = inc_ill;
		flt_set[sei_pkg::F_PP_TRK] = pp_trk;
		flt_set[sei_pkg::F_PP_ILL] = pp_ill;
		flt_set[sei_pkg::F_PAIR] = pair_eval && !own_smp && !peer_smp;
	end

	sequence s_fault_seen;
		##1 (|flt) ##1 fault;
	endsequence
	a_tick_single: assert property (tick |=> !tick [*8])
		else $error("processing tick repeated");
	a_freq_fast: assert property (rise && bits != 6'h00 && pcnt < 12'h010 |=> flt[sei_pkg::F_FREQ])
		else $error("fast ssi clock not flagged");
	a_plaus_flag: assert property (plaus_bad |=> flt[sei_pkg::F_PLAUS])
		else $error("plausibility fault not latched");
	a_gap_frame: assert property (gap_end |=> bits == 6'h00)
		else $error("idle gap did not close frame");
	a_gap_loss: assert property (!master && icnt == 24'(GAP_MAX - 1) && !edge_any
		|=> flt[sei_pkg::F_GAP]) else $error("missing listen clock not flagged");
	a_pair_fault: assert property (pair_eval && !own_smp && !peer_smp |=> flt[sei_pkg::F_PAIR])
		else $error("both switches low not flagged");
	a_pair_send: assert property ($rose(xch_sclk) |-> xch_mosi == own_smp)
		else $error("exchanged bit differs from sample");
	a_mst_half: assert property (ssi_clk_oe && $rose(ssi_clk_out)
		|-> $past(hcnt) == 10'(sei_pkg::SSI_HALF_CLKS - 1)) else $error("master clock rate");
	a_fault_latch: assert property ((|flt_set) |-> s_fault_seen)
		else $error("fault not reported");
	a_gray_conv: assert property (frame_ok && gray |=> pos == sei_g2b($past(raw)))
		else $error("gray position not converted");
endmodule : sei_monitor

/* core/sei_pkg.sv */
// constants, register map and state types of the safe encoder input monitor
package sei_pkg;
	localparam int CLK_KHZ = 100_000;
	localparam int CYCLE_MS = 8;
	localparam int CYCLE_CLKS = CYCLE_MS * CLK_KHZ;
	localparam int SSI_MST_KHZ = 150;
	localparam int SSI_HALF_CLKS = CLK_KHZ / (2 * SSI_MST_KHZ);
	localparam int GAP_MIN_US = 150;
	localparam int GAP_MIN_CLKS = GAP_MIN_US * CLK_KHZ / 1000;
	localparam int GAP_MAX_MS = 1;
	localparam int GAP_MAX_CLKS = GAP_MAX_MS * CLK_KHZ;
	localparam int FREQ_LO_KHZ = 100;
	localparam int FREQ_HI_KHZ = 350;
	localparam int PER_MAX_CLKS = CLK_KHZ / FREQ_LO_KHZ;
	localparam int PER_MIN_CLKS = CLK_KHZ / FREQ_HI_KHZ + 1;
	localparam int DATA_MIN = 12;
	localparam int DATA_MAX = 28;
	localparam int TRK_LIMIT = 4;
	localparam int DEB_US = 5;
	localparam int DEB_CLKS = DEB_US * CLK_KHZ / 1000;
	localparam int XCH_HALF_NS = 500;
	localparam int XCH_HALF_CLKS = XCH_HALF_NS * CLK_KHZ / 1_000_000;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_VEL = 8'h04;
	localparam logic [7:0] ADDR_FAULT = 8'h08;
	localparam logic [7:0] ADDR_POS = 8'h0c;
	localparam logic [7:0] ADDR_SSTAT = 8'h10;
	localparam logic [7:0] ADDR_INC = 8'h14;
	localparam logic [7:0] ADDR_PP = 8'h18;
	localparam logic [7:0] ADDR_PROX = 8'h1c;
	// control fields, control reset value and proximity register bits
	localparam int CTRL_MASTER = 0;
	localparam int CTRL_GRAY = 1;
	localparam int CTRL_DLEN_LSB = 8;
	localparam int CTRL_FLEN_LSB = 16;
	localparam logic [31:0] CTRL_RESET = 32'h001c_1600;
	localparam int PROX_OWN = 31;
	localparam int PROX_PEER = 30;
	// fault bits
	localparam int F_FREQ = 0;
	localparam int F_PLAUS = 1;
	localparam int F_FRAME = 2;
	localparam int F_GAP = 3;
	localparam int F_INC_TRK = 4;
	localparam int F_INC_ILL = 5;
	localparam int F_PP_TRK = 6;
	localparam int F_PP_ILL = 7;
	localparam int F_PAIR = 8;
	localparam int NFAULT = 9;
	typedef enum {SEI_M_IDLE, SEI_M_LOW, SEI_M_HIGH} sei_mst_t;
	typedef enum {SEI_X_IDLE, SEI_X_LOW, SEI_X_HIGH} sei_xch_t;
endpackage : sei_pkg

/* core/sei_sync.sv */
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module sei_sync #(
	parameter int W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : sei_sync

/* core/sei_quad.sv */
// quadrature decoder with per-track edge balance check
`timescale 1ns/1ps
module sei_quad #(
	parameter int CNT_W = 16,
	parameter int LIMIT = sei_pkg::TRK_LIMIT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic a,
	input wire logic b,
	output logic [CNT_W-1:0] count,
	output logic trk_err,
	output logic ill_err
);
	logic a_q, b_q;
	logic signed [7:0] bal;
	logic da, db;
	assign da = a ^ a_q;
	assign db = b ^ b_q;

	// count by which track leads; both moving at once is illegal
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			count <= '0;
			ill_err <= 1'b0;
		end else begin
			a_q <= a;
			b_q <= b;
			ill_err <= da & db;
			if ((da ^ db) && (a ^ b_q)) begin
				count <= count + CNT_W'(1);
			end else if (da ^ db) begin
				count <= count - CNT_W'(1);
			end
		end
	end

	// edges of a and b alternate; drift beyond the limit is a fault
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bal <= 8'sh00;
			trk_err <= 1'b0;
		end else begin
			trk_err <= (bal > 8'(LIMIT)) || (bal < -8'(LIMIT));
			if ((bal > 8'(LIMIT)) || (bal < -8'(LIMIT))) begin
				bal <= 8'sh00;
			end else if (da && !db) begin
				bal <= bal + 8'sh01;
			end else if (db && !da) begin
				bal <= bal - 8'sh01;
			end
		end
	end

	a_quad_illegal: assert property (@(posedge pclk) disable iff (!presetn)
		(da && db) |=> ill_err) else $error("double track change not flagged");
	a_track_excess: assert property (@(posedge pclk) disable iff (!presetn)
		(bal == 8'(LIMIT + 1)) |=> trk_err) else $error("track drift not flagged");
endmodule : sei_quad

/* testbench/sei_far_model.sv */
// far-side model: ssi absolute encoder and peer channel of the pair exchange
`timescale 1ns/1ps
module sei_far_model (
	input wire logic ssi_clk_out,
	input wire logic ssi_clk_oe,
	input wire logic xch_sclk,
	input wire logic xch_mosi,
	output logic ssi_clk_in,
	output logic ssi_data_in,
	output logic xch_miso
);
	logic [63:0] word = 64'h0000_0000_0000_0000;
	int flen = 28;
	int k = 0;
	logic peer = 1'b1;
	logic got = 1'b0;
	// lines idle until the first frame
	initial begin
		ssi_clk_in = 1'b1;
		ssi_data_in = 1'b1;
		xch_miso = 1'b0;
	end
	// master mode: next bit msb first after each falling clock edge
	always @(negedge ssi_clk_out) begin
		if (ssi_clk_oe && k < flen) begin
			ssi_data_in = word[flen-1-k];
			k = k + 1;
		end
	end
	// after the last bit the line is released: inverse of the last value
	always @(posedge ssi_clk_out) begin
		if (k >= flen) begin
			#1000 ssi_data_in = ~ssi_data_in;
			k = 0;
		end
	end
	// listening mode: the far system makes the clock, still and high between frames
	task automatic listen_frame(input int half_ns);
		#3;
		for (int i = 0; i < flen; i++) begin
			ssi_clk_in = 1'b0;
			ssi_data_in = word[flen-1-i];
			#(half_ns);
			ssi_clk_in = 1'b1;
			#(half_ns);
		end
		#1000 ssi_data_in = ~ssi_data_in;
	endtask : listen_frame
	// peer shows its status while the exchange clock is high, inverse otherwise
	always @(posedge xch_sclk) begin
		xch_miso = peer;
		got = xch_mosi;
	end
	always @(negedge xch_sclk) begin
		#100 xch_miso = ~peer;
	end
endmodule : sei_far_model

/* testbench/tb.sv */
// self-checking bench of the safe encoder input monitor
`timescale 1ns/1ps
module tb;
	localparam int CYC = 10000;
	localparam int GMIN = 1500;
	localparam int GMAX = 4000;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ssi_clk_in;
	logic ssi_data_in;
	logic ssi_clk_out;
	logic ssi_clk_oe;
	logic [1:0] qa = 2'b00;
	logic [1:0] qb = 2'b00;
	logic prox_in = 1'b0;
	logic xch_miso;
	logic xch_sclk;
	logic xch_mosi;
	logic fault;
	int failures = 0;
	int tests_run = 0;
	logic [31:0] rd;
	logic err;
	int ph[2] = '{0, 0};
	int ec[2] = '{0, 0};
	int pc = 0;
	int n;
	logic [63:0] w;
	logic [31:0] epos;
	int dl[3] = '{28, 12, 11};
	int fl[3] = '{30, 15, 15};
	int gy[3] = '{1, 0, 0};
	int hf[3] = '{2000, 2500, 80};
	logic own[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
	logic pr[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
	sei_monitor #(.CYC_CLKS(CYC), .GAP_MIN(GMIN), .GAP_MAX(GMAX), .CNT_W(16)) i_sei_monitor (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ssi_clk_in(ssi_clk_in), .ssi_data_in(ssi_data_in), .ssi_clk_out(ssi_clk_out),
		.ssi_clk_oe(ssi_clk_oe), .inc_a(qa[0]), .inc_b(qb[0]), .pp_a(qa[1]), .pp_b(qb[1]),
		.prox_in(prox_in), .xch_miso(xch_miso), .xch_sclk(xch_sclk), .xch_mosi(xch_mosi),
		.fault(fault)
	);
	sei_far_model i_sei_far_model (
		.ssi_clk_out(ssi_clk_out), .ssi_clk_oe(ssi_clk_oe), .xch_sclk(xch_sclk),
		.xch_mosi(xch_mosi), .ssi_clk_in(ssi_clk_in), .ssi_data_in(ssi_data_in),
		.xch_miso(xch_miso)
	);
	// free-running bus clock
	initial begin
		forever #5 pclk = ~pclk;
	end
	task automatic give_verdict;
		if (failures == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask : cyc
	// one apb transfer: held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int m;
		m = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			m++;
		end while (pready !== 1'b1 && m < 20);
		if (m >= 20) begin
			failures++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// bounded wait for the ssi clock or the exchange clock to reach a level
	task automatic wait_sig(input bit xch, input logic lvl);
		int m;
		m = 0;
		while (((xch ? xch_sclk : ssi_clk_out) !== lvl) && m < 30000) begin
			m++;
			@(posedge pclk);
		end
		if (m >= 30000) begin
			failures++;
			give_verdict();
		end
	endtask : wait_sig
	// one quadrature step; a step of two changes both tracks at once
	task automatic qstep(input int d, input int dir);
		ph[d] = (ph[d] + dir + 4) % 4;
		@(posedge pclk);
		qa[d] <= ph[d] == 1 || ph[d] == 2;
		qb[d] <= ph[d] >= 2;
		if (dir != 2) begin
			ec[d] += dir;
		end
		cyc(130);
	endtask : qstep
	function automatic logic [31:0] g2b(input logic [31:0] g);
		logic [31:0] b;
		b = g;
		for (int i = 30; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : g2b
	// main sequence
	initial begin
		void'($urandom(69057));
		cyc(8);
		presetn <= 1'b1;
		apb(0, sei_pkg::ADDR_CTRL, 0);
		check("ctrl", sei_pkg::CTRL_RESET, rd);
		check("clk_oe", 0, ssi_clk_oe);
		apb(0, 8'h20, 0);
		check("slverr", 1, err);
		check("unmapped", 0, rd);
		apb(1, sei_pkg::ADDR_VEL, 32'h1234_5678);
		apb(0, sei_pkg::ADDR_VEL, 0);
		check("vel", 32'h1234_5678, rd);
		cyc(GMAX + 100);
		apb(0, sei_pkg::ADDR_FAULT, 0);
		check("lost", 32'h0000_0008, rd & 32'h0000_0008);
		check("fault_pin", 1, fault);
		// listening frames: longest gray, shortest binary, then a bad length too fast
		epos = 0;
		for (int i = 0; i < 3; i++) begin
			apb(1, sei_pkg::ADDR_CTRL, 32'((gy[i] << 1) | (dl[i] << 8) | (fl[i] << 16)));
			apb(1, sei_pkg::ADDR_FAULT, 32'h0000_01ff);
			w = {$urandom, $urandom};
			i_sei_far_model.word = w;
			i_sei_far_model.flen = fl[i];
			i_sei_far_model.listen_frame(hf[i]);
			cyc(GMIN + 50);
			apb(0, sei_pkg::ADDR_FAULT, 0);
			check("frame_err", (i == 2) ? 5 : 0, rd & 32'h0000_0005);
			if (i < 2) begin
				epos = 32'((w >> (fl[i] - dl[i])) & ((64'h1 << dl[i]) - 1));
				epos = gy[i] ? g2b(epos) : epos;
				apb(0, sei_pkg::ADDR_SSTAT, 0);
				check("status", 32'(w & ((64'h1 << (fl[i] - dl[i])) - 1)), rd);
			end
			apb(0, sei_pkg::ADDR_POS, 0);
			check("pos", epos, rd);
		end
		// clock master: frame at each tick, then a jump beyond the velocity bound
		w = 64'($urandom % 3000);
		i_sei_far_model.word = w;
		i_sei_far_model.flen = 12;
		apb(1, sei_pkg::ADDR_VEL, 32'h0001_0000);
		apb(1, sei_pkg::ADDR_CTRL, 32'h000c_0c01);
		wait_sig(0, 1'b0);
		n = 0;
		while (ssi_clk_out === 1'b0 && n < 1000) begin
			n++;
			@(posedge pclk);
		end
		check("clk_oe", 1, ssi_clk_oe);
		check("half", sei_pkg::SSI_HALF_CLKS, n);
		cyc(CYC);
		apb(0, sei_pkg::ADDR_POS, 0);
		check("pos_mst", w[31:0], rd);
		apb(1, sei_pkg::ADDR_VEL, 32'h0000_0001);
		apb(1, sei_pkg::ADDR_FAULT, 32'h0000_01ff);
		i_sei_far_model.word = w + 100;
		cyc(2 * CYC + 200);
		apb(0, sei_pkg::ADDR_POS, 0);
		check("pos_jump", w[31:0] + 100, rd);
		apb(0, sei_pkg::ADDR_FAULT, 0);
		check("plaus", 32'h0000_0002, rd & 32'h0000_0003);
		// quadrature decoders: balance at the limit, one past it, then a double change
		for (int d = 0; d < 2; d++) begin
			apb(1, sei_pkg::ADDR_FAULT, 32'h0000_01ff);
			repeat (8) qstep(d, 1);
			repeat (3) qstep(d, -1);
			repeat (5) qstep(d, ph[d] == 1 ? -1 : 1);
			cyc(10);
			apb(0, d ? sei_pkg::ADDR_PP : sei_pkg::ADDR_INC, 0);
			check("count", 32'(16'(ec[d])), rd & 32'h0000_ffff);
			apb(0, sei_pkg::ADDR_FAULT, 0);
			check("trk_ok", 0, (rd >> (4 + 2 * d)) & 3);
			qstep(d, ph[d] == 1 ? -1 : 1);
			apb(0, sei_pkg::ADDR_FAULT, 0);
			check("trk", 1, (rd >> (4 + 2 * d)) & 3);
			qstep(d, 2);
			apb(0, sei_pkg::ADDR_FAULT, 0);
			check("ill", 2, (rd >> (4 + 2 * d)) & 2);
		end
		// proximity: a glitch is not counted, then all four pair states
		@(posedge pclk);
		prox_in <= 1'b1;
		cyc(100);
		prox_in <= 1'b0;
		cyc(600);
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			prox_in <= own[i];
			i_sei_far_model.peer = pr[i];
			pc += (own[i] && (i == 0 || !own[i-1])) ? 1 : 0;
			cyc(620);
			apb(1, sei_pkg::ADDR_FAULT, 32'h0000_01ff);
			wait_sig(1, 1'b1);
			wait_sig(1, 1'b0);
			cyc(10);
			apb(0, sei_pkg::ADDR_PROX, 0);
			check("prox", {own[i], pr[i], 14'h0000, 16'(pc)}, rd & 32'hc000_ffff);
			check("sent", own[i], i_sei_far_model.got);
			apb(0, sei_pkg::ADDR_FAULT, 0);
			check("pair", {23'h00_0000, !(own[i] | pr[i]), 8'h00}, rd);
			check("fault_pin", !(own[i] | pr[i]), fault);
		end
		give_verdict();
	end
endmodule : tb
